// file: sil_pkg.sv
// Register map and field layout of the debug port system interface layer.
// Assumes an 8-bit register access from the port's access layer.
package sil_pkg;
    localparam logic [3:0] CTRL_DIV_OFFSET = 4'h9;
    localparam logic [3:0] SYS_CTRL_OFFSET = 4'ha;
    localparam logic [3:0] SYS_STATUS_OFFSET = 4'hb;
    localparam logic [3:0] CRC_STATUS_OFFSET = 4'hc;
    localparam logic [3:0] MESSAGE_OFFSET = 4'hd;
    localparam logic [3:0] RESET_REQ_OFFSET = 4'h8;
    localparam logic [1:0] DIV_RESET = 2'h3;
    localparam logic [1:0] DIV_RECOMMENDED = 2'h2;
    localparam logic [7:0] SYS_CTRL_RESET = 8'h00;
    localparam logic [7:0] SYS_STATUS_RESET = 8'h01;
    localparam logic [7:0] RESET_SIGNATURE = 8'h59;
    localparam int CLK_REQ_BIT = 0;
    localparam int ROW_DONE_BIT = 1;
    localparam int LOCKED_BIT = 0;
    localparam int BOOT_BIT = 1;
    localparam int ROW_PROG_BIT = 2;
    localparam int NVM_PROG_BIT = 3;
    localparam int ASLEEP_BIT = 4;
    localparam int RST_ACTIVE_BIT = 5;
    localparam logic [2:0] CRC_OFF = 3'h0;
    localparam logic [2:0] CRC_BUSY = 3'h1;
    localparam logic [2:0] CRC_OK = 3'h2;
    localparam logic [2:0] CRC_FAIL = 3'h3;
endpackage : sil_pkg

// file: sil_sync.sv
// Two-flip-flop synchroniser for levels arriving from the system domain.
// Assumes inputs change slowly compared with the clock.
`timescale 1ns/1ps
module sil_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage;

    if (WIDTH < 1) begin : g_width_check
        $error("synchroniser width must be at least one");
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stage <= '0;
            sync_out <= '0;
        end else begin
            stage <= async_in;
            sync_out <= stage;
        end
    end
endmodule : sil_sync

// file: sil_clock_div.sv
// Port clock divider: a one-cycle tick at the selected fraction of the clock.
// Assumes clock is the undivided internal oscillator.
`timescale 1ns/1ps
module sil_clock_div (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Control
    input wire logic [1:0] div_select,
    output logic port_tick
);
    logic [2:0] count;
    logic [2:0] limit;

    // Divide by 2 to the power of the select code
    always_comb begin
        limit = 3'((4'h1 << div_select) - 4'h1);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
            port_tick <= 1'b0;
        end else if (count >= limit) begin
            count <= '0;
            port_tick <= 1'b1;
        end else begin
            count <= count + 3'h1;
            port_tick <= 1'b0;
        end
    end
endmodule : sil_clock_div

// file: sil_regs.sv
// System interface layer registers of the single-pin debug port.
// Assumes register accesses come from the access layer on clock; system-side
// status levels come from another domain and are synchronised here.
`timescale 1ns/1ps

// Notes on behaviour
// - Divider select, reset code 3, divide 8
// - Row-done write lets boot code continue
// - Row-done write needs active user-row key
// - Early row-done write gets no protection
// - Clock request bit drives system clock request
// - Clock request cleared disabled, set enabled
// - Reset-active sticky while reset, clear on read
// - Asleep bit follows system sleep state
// - Memory-programming permission from boot code
// - Row-programming permission, adapter then writes done
// - Boot complete bit gates access layer
// - Locked bit resets one, clears after erase
// - CRC status field encodes four states
// - CPU message byte readable by port only
// - Message read clears message valid flag
// - Signature 0x59 holds reset, bit0 shows
module sil_regs
    import sil_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register access from access layer
    input wire logic [3:0] reg_addr,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Port enable and keys
    input wire logic port_enabled,
    input wire logic row_key_active,
    // System-side status, asynchronous
    input wire logic sys_in_reset,
    input wire logic sys_asleep,
    input wire logic sys_nvm_permit,
    input wire logic sys_row_permit,
    input wire logic sys_boot_done,
    input wire logic sys_locked,
    input wire logic [2:0] sys_crc_state,
    input wire logic sys_msg_written,
    input wire logic [7:0] sys_msg_byte,
    // Outputs to system and port
    output logic system_clock_request,
    output logic user_row_done,
    output logic system_reset_hold,
    output logic access_layer_open,
    output logic port_tick,
    output logic cpu_message_valid
);
    logic [1:0] port_clock_divider_select;
    logic system_reset_active;
    logic [7:0] cpu_message_byte;
    logic [15:0] sync_status;
    logic [7:0] sync_msg;
    logic msg_seen;
    logic tick_raw;
    logic enabled_prev;
    logic [1:0] locked_sync;

    function automatic logic hit(input logic [3:0] addr, input logic [3:0] offset);
        return addr == offset;
    endfunction : hit

    // Synchronised vector: 15 message written, 14 in reset, 13 asleep,
    // 12 memory permit, 11 row permit, 10 boot done, 8:6 CRC state,
    // 5 port enabled, 4 row key; bit 9 and bits 3:0 are spare
    sil_sync #(.WIDTH(16)) u_status_sync (
        .clock(clock),
        .rst_n(rst_n),
        .async_in({sys_msg_written, sys_in_reset, sys_asleep, sys_nvm_permit, sys_row_permit,
                   sys_boot_done, 1'b0, sys_crc_state, port_enabled, row_key_active,
                   4'h0}),
        .sync_out(sync_status)
    );

    sil_sync #(.WIDTH(8)) u_msg_sync (
        .clock(clock),
        .rst_n(rst_n),
        .async_in(sys_msg_byte),
        .sync_out(sync_msg)
    );

    sil_clock_div u_div (
        .clock(clock),
        .rst_n(rst_n),
        .div_select(port_clock_divider_select),
        .port_tick(tick_raw)
    );

    // Divider select; other settings are the adapter's choice
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            port_clock_divider_select <= DIV_RESET;
        end else if (reg_write && hit(reg_addr, CTRL_DIV_OFFSET)) begin
            port_clock_divider_select <= reg_wdata[1:0];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            port_tick <= 1'b0;
        end else begin
            port_tick <= tick_raw;
        end
    end

    // Clock request follows enable edges, then software writes
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            enabled_prev <= 1'b0;
            system_clock_request <= SYS_CTRL_RESET[CLK_REQ_BIT];
        end else begin
            enabled_prev <= sync_status[5];
            if (!sync_status[5]) begin
                system_clock_request <= 1'b0;
            end else if (!enabled_prev) begin
                system_clock_request <= 1'b1;
            end else if (reg_write && hit(reg_addr, SYS_CTRL_OFFSET)) begin
                system_clock_request <= reg_wdata[CLK_REQ_BIT];
            end
        end
    end

    // No check against row data already in RAM: early writes go through
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            user_row_done <= SYS_CTRL_RESET[ROW_DONE_BIT];
        end else if (reg_write && hit(reg_addr, SYS_CTRL_OFFSET) && sync_status[4]) begin
            user_row_done <= reg_wdata[ROW_DONE_BIT];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            system_reset_hold <= 1'b0;
        end else if (reg_write && hit(reg_addr, RESET_REQ_OFFSET)) begin
            system_reset_hold <= (reg_wdata == RESET_SIGNATURE);
        end
    end

    // Sticky; a live reset wins over the read clear
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            system_reset_active <= SYS_STATUS_RESET[RST_ACTIVE_BIT];
        end else if (sync_status[14] || system_reset_hold) begin
            system_reset_active <= 1'b1;
        end else if (reg_read && hit(reg_addr, SYS_STATUS_OFFSET)) begin
            system_reset_active <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            access_layer_open <= 1'b0;
        end else begin
            access_layer_open <= sync_status[10];
        end
    end

    // Lock has its own pair so it reads locked straight out of reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            locked_sync <= {2{SYS_STATUS_RESET[LOCKED_BIT]}};
        end else begin
            locked_sync <= {locked_sync[0], sys_locked};
        end
    end

    // Message capture on write edge; a new write wins over a read clear
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            msg_seen <= 1'b0;
            cpu_message_byte <= '0;
            cpu_message_valid <= 1'b0;
        end else begin
            msg_seen <= sync_status[15];
            if (sync_status[15] && !msg_seen) begin
                cpu_message_byte <= sync_msg;
                cpu_message_valid <= 1'b1;
            end else if (reg_read && hit(reg_addr, MESSAGE_OFFSET)) begin
                cpu_message_valid <= 1'b0;
            end
        end
    end

    // Read mux; unmapped and unused bits read zero
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_read) begin
            unique case (reg_addr)
                CTRL_DIV_OFFSET: reg_rdata <= {6'h0, port_clock_divider_select};
                SYS_CTRL_OFFSET: reg_rdata <= {6'h0, user_row_done, system_clock_request};
                SYS_STATUS_OFFSET: reg_rdata <= {2'h0, system_reset_active | sync_status[14],
                    sync_status[13], sync_status[12], sync_status[11],
                    sync_status[10], locked_sync[1]};
                CRC_STATUS_OFFSET: reg_rdata <= {5'h0, sync_status[8:6]};
                MESSAGE_OFFSET: reg_rdata <= cpu_message_byte;
                RESET_REQ_OFFSET: reg_rdata <= {7'h0, system_reset_hold};
                default: reg_rdata <= '0;
            endcase
        end
    end

    AST_DIV_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
        reg_write && hit(reg_addr, CTRL_DIV_OFFSET) |=> port_clock_divider_select == $past(reg_wdata[1:0]))
        else $error("divider select not written");

    AST_DIV_READ: assert property (@(posedge clock) disable iff (!rst_n)
        reg_read && hit(reg_addr, CTRL_DIV_OFFSET) |=> reg_rdata == {6'h0, $past(port_clock_divider_select)})
        else $error("divider select read wrong");

    AST_ROW_KEY: assert property (@(posedge clock) disable iff (!rst_n)
        !sync_status[4] |=> $stable(user_row_done))
        else $error("row done changed without key");

    AST_ROW_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
        sync_status[4] && reg_write && hit(reg_addr, SYS_CTRL_OFFSET)
        |=> user_row_done == $past(reg_wdata[ROW_DONE_BIT]))
        else $error("row done not written with key");

    AST_CLK_DISABLED: assert property (@(posedge clock) disable iff (!rst_n)
        !sync_status[5] |=> !system_clock_request)
        else $error("clock request held while disabled");

    AST_CLK_ENABLE: assert property (@(posedge clock) disable iff (!rst_n)
        sync_status[5] && !enabled_prev |=> system_clock_request)
        else $error("clock request not raised on enable");

    AST_CLK_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
        sync_status[5] && enabled_prev && reg_write && hit(reg_addr, SYS_CTRL_OFFSET)
        |=> system_clock_request == $past(reg_wdata[CLK_REQ_BIT]))
        else $error("clock request not written");

    AST_CTRL_READ: assert property (@(posedge clock) disable iff (!rst_n)
        reg_read && hit(reg_addr, SYS_CTRL_OFFSET)
        |=> reg_rdata[ROW_DONE_BIT] == $past(user_row_done) && reg_rdata[CLK_REQ_BIT] == $past(system_clock_request)
            && reg_rdata[7:2] == 6'h0)
        else $error("control read wrong");

    AST_RESET_SIG: assert property (@(posedge clock) disable iff (!rst_n)
        reg_write && hit(reg_addr, RESET_REQ_OFFSET) |=> system_reset_hold == ($past(reg_wdata) == RESET_SIGNATURE))
        else $error("reset signature decode wrong");

    AST_HOLD_READ: assert property (@(posedge clock) disable iff (!rst_n)
        reg_read && hit(reg_addr, RESET_REQ_OFFSET) |=> reg_rdata == {7'h0, $past(system_reset_hold)})
        else $error("reset request read wrong");

    AST_RST_STICKY: assert property (@(posedge clock) disable iff (!rst_n)
        system_reset_hold |=> system_reset_active)
        else $error("reset active not set");

    AST_RST_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
        reg_read && hit(reg_addr, SYS_STATUS_OFFSET) && !sync_status[14] && !system_reset_hold
        |=> !system_reset_active)
        else $error("reset active not cleared by read");

    AST_STATUS_READ: assert property (@(posedge clock) disable iff (!rst_n)
        reg_read && hit(reg_addr, SYS_STATUS_OFFSET)
        |=> reg_rdata[ASLEEP_BIT] == $past(sync_status[13])
            && reg_rdata[NVM_PROG_BIT] == $past(sync_status[12])
            && reg_rdata[ROW_PROG_BIT] == $past(sync_status[11])
            && reg_rdata[BOOT_BIT] == $past(sync_status[10])
            && reg_rdata[LOCKED_BIT] == $past(locked_sync[1])
            && reg_rdata[7:6] == 2'h0)
        else $error("status bit out of place");

    AST_ACCESS_GATE: assert property (@(posedge clock) disable iff (!rst_n)
        !sync_status[10] |=> !access_layer_open)
        else $error("access layer open before boot done");

    AST_CRC_READ: assert property (@(posedge clock) disable iff (!rst_n)
        reg_read && hit(reg_addr, CRC_STATUS_OFFSET) |=> reg_rdata == {5'h0, $past(sync_status[8:6])})
        else $error("crc status read wrong");

    AST_MSG_CAPTURE: assert property (@(posedge clock) disable iff (!rst_n)
        sync_status[15] && !msg_seen |=> cpu_message_valid && cpu_message_byte == $past(sync_msg))
        else $error("message not captured");

    AST_MSG_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
        reg_read && hit(reg_addr, MESSAGE_OFFSET) && !(sync_status[15] && !msg_seen) |=> !cpu_message_valid)
        else $error("message valid not cleared");

    AST_UNMAPPED: assert property (@(posedge clock) disable iff (!rst_n)
        reg_read && reg_addr > MESSAGE_OFFSET |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");

    COV_MSG: cover property (@(posedge clock) disable iff (!rst_n) cpu_message_valid ##[1:20] !cpu_message_valid);
    COV_RESET: cover property (@(posedge clock) disable iff (!rst_n) $rose(system_reset_hold));
    COV_ROW: cover property (@(posedge clock) disable iff (!rst_n) $rose(user_row_done));
    COV_ENABLE: cover property (@(posedge clock) disable iff (!rst_n) $rose(system_clock_request));
    COV_ACCESS: cover property (@(posedge clock) disable iff (!rst_n) $rose(access_layer_open));
endmodule : sil_regs

// file: adapter_model.sv
// Register-access side of the debug adapter facing the system interface layer.
// Assumes the bench calls access(); lines change on the falling clock edge.
`timescale 1ns/1ps
module adapter_model (
    // Clock
    input wire logic clock,
    // Register access
    output logic [3:0] reg_addr,
    output logic reg_write,
    output logic reg_read,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 4'h0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_wdata = 8'h00;
    end

    task automatic access(input logic [3:0] addr, input logic wr, input logic [7:0] data,
                          output logic [7:0] rdata);
        @(negedge clock);
        reg_addr = addr;
        reg_wdata = data;
        reg_write = wr;
        reg_read = !wr;
        @(negedge clock);
        reg_write = 1'b0;
        reg_read = 1'b0;
        // Released lines must not keep their last value
        reg_addr = ~addr;
        reg_wdata = ~data;
        rdata = reg_rdata;
    endtask : access
endmodule : adapter_model

// file: sil_regs_tb.sv
// Self-checking bench for the system interface layer registers.
// Assumes adapter_model issues accesses; system-side levels come from here.
`timescale 1ns/1ps
module sil_regs_tb;
    import sil_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr;
    logic reg_write, reg_read;
    logic [7:0] reg_wdata, reg_rdata;
    logic port_enabled = 1'b0;
    logic row_key_active = 1'b0;
    logic [5:0] sys_levels = 6'h01;
    logic [2:0] sys_crc_state = 3'h0;
    logic sys_msg_written = 1'b0;
    logic [7:0] sys_msg_byte = 8'h00;
    logic system_clock_request, user_row_done, system_reset_hold, access_layer_open, port_tick, cpu_message_valid;
    int errors = 0;
    int num_checks = 0;

    always #4 clock = ~clock;

    adapter_model i_adapter (.clock(clock), .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    sil_regs i_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_write(reg_write),
        .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .port_enabled(port_enabled),
        .row_key_active(row_key_active), .sys_in_reset(sys_levels[5]), .sys_asleep(sys_levels[4]),
        .sys_nvm_permit(sys_levels[3]), .sys_row_permit(sys_levels[2]), .sys_boot_done(sys_levels[1]),
        .sys_locked(sys_levels[0]), .sys_crc_state(sys_crc_state), .sys_msg_written(sys_msg_written),
        .sys_msg_byte(sys_msg_byte), .system_clock_request(system_clock_request),
        .user_row_done(user_row_done), .system_reset_hold(system_reset_hold),
        .access_layer_open(access_layer_open), .port_tick(port_tick), .cpu_message_valid(cpu_message_valid));

    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask : idle

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] unused;
        i_adapter.access(a, 1'b1, d, unused);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string name);
        logic [7:0] got;
        i_adapter.access(a, 1'b0, 8'h00, got);
        chk(name, exp, got);
    endtask : rd

    task automatic reset_values();
        rd(CTRL_DIV_OFFSET, {6'h00, DIV_RESET}, "divider reset");
        rd(SYS_STATUS_OFFSET, SYS_STATUS_RESET, "status reset");
        rd(SYS_CTRL_OFFSET, SYS_CTRL_RESET, "control reset");
        rd(RESET_REQ_OFFSET, 8'h00, "reset request reset");
    endtask : reset_values

    task automatic divider_codes();
        int ticks;
        for (int d = 0; d < 4; d++) begin
            wr(CTRL_DIV_OFFSET, 8'hfc | 8'(d));
            rd(CTRL_DIV_OFFSET, 8'(d), "divider select");
            idle(16);
            ticks = 0;
            repeat (64) begin
                @(negedge clock);
                ticks += int'(port_tick === 1'b1);
            end
            chk("tick count", 8'(64 >> d), 8'(ticks));
        end
        wr(CTRL_DIV_OFFSET, {6'h00, DIV_RECOMMENDED});
    endtask : divider_codes

    task automatic clock_request();
        chk("request while disabled", 8'h00, {7'h0, system_clock_request});
        port_enabled = 1'b1;
        idle(4);
        chk("request on enable", 8'h01, {7'h0, system_clock_request});
        wr(SYS_CTRL_OFFSET, 8'h00);
        chk("request dropped", 8'h00, {7'h0, system_clock_request});
        wr(SYS_CTRL_OFFSET, 8'h01);
        chk("request raised", 8'h01, {7'h0, system_clock_request});
        port_enabled = 1'b0;
        idle(4);
        wr(SYS_CTRL_OFFSET, 8'h01);
        chk("request disabled", 8'h00, {7'h0, system_clock_request});
        port_enabled = 1'b1;
        idle(4);
        chk("request re-enabled", 8'h01, {7'h0, system_clock_request});
    endtask : clock_request

    task automatic row_done();
        wr(SYS_CTRL_OFFSET, 8'hfe);
        chk("row done no key", 8'h00, {7'h0, user_row_done});
        rd(SYS_CTRL_OFFSET, 8'h00, "control no key");
        row_key_active = 1'b1;
        idle(4);
        wr(SYS_CTRL_OFFSET, 8'hff);
        chk("row done", 8'h01, {7'h0, user_row_done});
        rd(SYS_CTRL_OFFSET, 8'h03, "control readback");
    endtask : row_done

    task automatic status_bits();
        for (int b = 0; b < 5; b++) begin
            sys_levels = 6'(1 << b);
            idle(4);
            rd(SYS_STATUS_OFFSET, 8'(1 << b), "status bit");
            chk("access open", 8'(b == BOOT_BIT), {7'h0, access_layer_open});
        end
        wr(SYS_STATUS_OFFSET, 8'hff);
        rd(SYS_STATUS_OFFSET, 8'h10, "status write");
        sys_levels = 6'h20;
        idle(5);
        sys_levels = 6'h00;
        idle(4);
        rd(SYS_STATUS_OFFSET, 8'h20, "reset sticky");
        rd(SYS_STATUS_OFFSET, 8'h00, "reset cleared");
    endtask : status_bits

    task automatic reset_request();
        wr(RESET_REQ_OFFSET, RESET_SIGNATURE);
        chk("reset hold", 8'h01, {7'h0, system_reset_hold});
        rd(RESET_REQ_OFFSET, 8'h01, "reset request read");
        wr(RESET_REQ_OFFSET, 8'h58);
        chk("reset released", 8'h00, {7'h0, system_reset_hold});
        rd(RESET_REQ_OFFSET, 8'h00, "reset request clear");
    endtask : reset_request

    task automatic crc_and_message();
        int n;
        for (int c = 0; c < 4; c++) begin
            sys_crc_state = 3'(c);
            idle(4);
            rd(CRC_STATUS_OFFSET, 8'(c), "crc status");
        end
        sys_msg_byte = 8'ha5;
        idle(3);
        sys_msg_written = 1'b1;
        n = 0;
        while (cpu_message_valid !== 1'b1 && n < 10) begin
            idle(1);
            n++;
        end
        if (cpu_message_valid !== 1'b1) begin
            errors++;
            complete_run();
        end
        wr(MESSAGE_OFFSET, 8'h00);
        rd(MESSAGE_OFFSET, 8'ha5, "message byte");
        chk("message valid", 8'h00, {7'h0, cpu_message_valid});
        rd(4'hf, 8'h00, "unmapped");
    endtask : crc_and_message

    initial begin
        repeat (3) @(negedge clock);
        rst_n = 1'b1;
        idle(4);
        reset_values();
        divider_codes();
        clock_request();
        row_done();
        status_bits();
        reset_request();
        crc_and_message();
        complete_run();
    end
endmodule : sil_regs_tb
